// ### pkg/aic_pkg.sv
package aic_pkg;

  // Register byte addresses on the Wishbone slave.
  localparam logic [7:0] ADR_MODE = 8'h00;
  localparam logic [7:0] ADR_GROUP = 8'h04;
  localparam logic [7:0] ADR_CTRL = 8'h08;
  localparam logic [7:0] ADR_CMD = 8'h0C;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  localparam logic [7:0] ADR_LINENUM = 8'h14;
  localparam logic [1:0] ADR_MEM_HI = 2'h1;

  // Channel groups for the group mode command; channel 4 sits in both.
  localparam logic [7:0] GRP_LOW_MASK = 8'h1F;
  localparam logic [7:0] GRP_HIGH_MASK = 8'hF0;
  localparam int GRP_UPPER_BIT = 0;
  localparam int GRP_LATCH_BIT = 1;

  // Control register fields.
  localparam int CTRL_ANALOG_BIT = 8;
  localparam int CTRL_SCROLL_BIT = 9;
  localparam int CTRL_AUTO_BIT = 10;
  localparam logic [7:0] PERIOD_FASTEST = 8'h01;
  localparam logic [7:0] PERIOD_RESET = 8'h04;

  // Command register fields, each a one-shot on write.
  localparam int CMD_ARM_BIT = 0;
  localparam int CMD_STEP_BIT = 1;
  localparam int CMD_SENS_BIT = 2;
  localparam int CMD_OFS_BIT = 3;

  // Status register field positions.
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_LINE_LSB = 1;
  localparam int ST_LNUM_LSB = 4;
  localparam int ST_SENS_LSB = 11;
  localparam int ST_OFS_LSB = 13;
  localparam int ST_AUTO_BIT = 17;

  // Analog front-end selector ranges; offset is two's complement volts.
  localparam logic [1:0] SENS_LAST = 2'h2;
  localparam logic [1:0] SENS_RESET = 2'h0;
  localparam logic [3:0] OFS_MAX = 4'h5;
  localparam logic [3:0] OFS_MIN = 4'hB;
  localparam logic [3:0] OFS_RESET = 4'h0;

  // Scroll line numbering.
  localparam logic [6:0] LNUM_MAX = 7'h63;
  localparam int SCROLL_LINES = 8;

  // Recording setup handed to the capture domain at each arm.
  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] period;
    logic analog;
    logic scroll;
    logic [2:0] line;
  } aic_cfg_t;

  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_WAIT = 1'b1
  } aic_rd_st_t;

endpackage

// ### verilog/aic_capture.sv
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/100ps

// Overview of operation
// R1 - Each of eight channels has its own sample or latch mode bit.
// R2 - Group command sets mode of channels 0-4 or 4-7 by physical number.
// R3 - Sample mode stores only the level at each active capture edge.
// R4 - Latch mode flags a transition between active edges whose level has come back by the next edge as a glitch.
// R5 - Glitch is recorded two intervals long, inverse of previous sampled level.
// R6 - Glitch detection runs at full link rate, whatever capture period is chosen.
// R7 - With the fastest capture period latch mode is off; channels just sample.
// R8 - Only glitch presence and its cell interval are recorded, not its width.
// R9 - After reset every channel is in sample mode.
// R10 - Analog recording puts 4-bit converter data on channels 0 to 3.
// R11 - Sensitivity key steps cyclically through three settings.
// R12 - Offset key steps in one-volt steps across plus five to minus five.
// R13 - Scroll arm records probe 7 alone into the selected display line.
// R14 - Line numbers stay 0 to 99, start at 0, rise by one per line.
// R15 - Auto scroll advances line and number after each recording.
// R16 - Step scroll advances only on step, wrapping from line 8 to line 1.
// R17 - Arming on a recorded scroll line overwrites that line.
// R18 - Each glitch detector is cleared once its interval is committed.
module aic_capture #(
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cap_clk_i,
  input wire logic [7:0] probe_i,
  input wire logic [3:0] adc_i,
  output logic [1:0] sens_o,
  output logic [3:0] offset_o,
  output logic auto_scroll_indicator_o,
  output logic busy_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [3:0] DEPTH_W = 4'(DEPTH - 1);

  // The memory window holds at most sixteen words above the register map.
  if (DEPTH < 2 || DEPTH > 16) begin : g_depth_chk
    $error("DEPTH must lie between 2 and 16");
  end

  // Next sensitivity setting; the three ranges repeat in a loop.
  function automatic logic [1:0] sens_step(input logic [1:0] s);
    sens_step = (s == aic_pkg::SENS_LAST) ? 2'h0 : 2'(s + 2'h1);
  endfunction

  // Next offset setting, walking down one volt and wrapping to the top.
  function automatic logic [3:0] ofs_step(input logic [3:0] o);
    ofs_step = (o == aic_pkg::OFS_MIN) ? aic_pkg::OFS_MAX : 4'(o - 4'h1);
  endfunction

  // Next line number, kept inside two decimal digits.
  function automatic logic [6:0] lnum_step(input logic [6:0] n);
    lnum_step = (n >= aic_pkg::LNUM_MAX) ? 7'h00 : 7'(n + 7'h1);
  endfunction

  // ---------------- System clock domain ----------------

  logic ack_r;
  logic [31:0] dat_r;
  logic [7:0] mode_r;
  logic [7:0] period_r;
  logic analog_r;
  logic scroll_r;
  logic auto_r;
  logic [1:0] sens_r;
  logic [3:0] ofs_r;
  logic busy_r;
  logic arm_tgl_r;
  aic_pkg::aic_cfg_t snap_r;
  logic [2:0] sel_r;
  logic [6:0] lnum_r [aic_pkg::SCROLL_LINES];
  aic_pkg::aic_rd_st_t rd_st_r;
  logic [AW-1:0] rd_idx_r;
  logic rq_tgl_r;
  logic rak_s1_r, rak_s2_r, rak_s3_r;
  logic dn_s1_r, dn_s2_r, dn_s3_r;
  logic [7:0] rd_data_r;
  logic rak_tgl_r;
  logic done_tgl_r;

  logic req, wr, rd, is_mem, rd_fire, done_ev, rak_ev;
  logic arm_cmd, step_cmd, adv;
  logic [31:0] reg_rdata;

  // Single-cycle requests are answered one cycle later; memory reads wait for the crossing.
  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;
  assign is_mem = (wb_adr_i[7:6] == aic_pkg::ADR_MEM_HI) && (wb_adr_i[5:2] <= DEPTH_W);
  assign rak_ev = rak_s2_r ^ rak_s3_r;
  assign done_ev = dn_s2_r ^ dn_s3_r;
  assign rd_fire = (rd_st_r == aic_pkg::RD_WAIT) & rak_ev;
  assign arm_cmd = wr & wb_sel_i[0] & (wb_adr_i == aic_pkg::ADR_CMD)
                   & wb_dat_i[aic_pkg::CMD_ARM_BIT];
  assign step_cmd = wr & wb_sel_i[0] & (wb_adr_i == aic_pkg::ADR_CMD)
                    & wb_dat_i[aic_pkg::CMD_STEP_BIT] & scroll_r;
  assign adv = step_cmd | (done_ev & snap_r.scroll & auto_r); // see R15 see R16

  // Register read mux; unmapped words read as zero.
  always_comb begin
    reg_rdata = 32'h0;
    case (wb_adr_i)
      aic_pkg::ADR_MODE: reg_rdata = {24'h0, mode_r};
      aic_pkg::ADR_CTRL: reg_rdata = {21'h0, auto_r, scroll_r, analog_r, period_r};
      aic_pkg::ADR_STATUS: begin
        reg_rdata[aic_pkg::ST_BUSY_BIT] = busy_r;
        reg_rdata[aic_pkg::ST_LINE_LSB +: 3] = sel_r;
        reg_rdata[aic_pkg::ST_LNUM_LSB +: 7] = lnum_r[sel_r];
        reg_rdata[aic_pkg::ST_SENS_LSB +: 2] = sens_r;
        reg_rdata[aic_pkg::ST_OFS_LSB +: 4] = ofs_r;
        reg_rdata[aic_pkg::ST_AUTO_BIT] = scroll_r & auto_r;
      end
      default: reg_rdata = 32'h0;
    endcase
  end

  // Bus answer: ack and read data both come from flip-flops.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= rd_fire | (req & ~(is_mem & ~wb_we_i));
      if (rd_fire) begin
        dat_r <= {24'h0, rd_data_r};
      end else if (rd & ~is_mem) begin
        dat_r <= reg_rdata;
      end
    end
  end

  // Per-channel modes; a group write touches only its own channels.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= 8'h00; // see R9
    end else if (wr & wb_sel_i[0] & (wb_adr_i == aic_pkg::ADR_MODE)) begin
      mode_r <= wb_dat_i[7:0]; // see R1
    end else if (wr & wb_sel_i[0] & (wb_adr_i == aic_pkg::ADR_GROUP)) begin
      if (wb_dat_i[aic_pkg::GRP_UPPER_BIT]) begin
        mode_r <= wb_dat_i[aic_pkg::GRP_LATCH_BIT] ? (mode_r | aic_pkg::GRP_HIGH_MASK)
                                                    : (mode_r & ~aic_pkg::GRP_HIGH_MASK); // see R2
      end else begin
        mode_r <= wb_dat_i[aic_pkg::GRP_LATCH_BIT] ? (mode_r | aic_pkg::GRP_LOW_MASK)
                                                    : (mode_r & ~aic_pkg::GRP_LOW_MASK); // see R2
      end
    end
  end

  // Capture period and recording flags; a zero period is taken as the fastest.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_r <= aic_pkg::PERIOD_RESET;
      analog_r <= 1'b0;
      scroll_r <= 1'b0;
      auto_r <= 1'b0;
    end else if (wr & (wb_adr_i == aic_pkg::ADR_CTRL)) begin
      if (wb_sel_i[0]) begin
        period_r <= (wb_dat_i[7:0] == 8'h00) ? aic_pkg::PERIOD_FASTEST : wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        analog_r <= wb_dat_i[aic_pkg::CTRL_ANALOG_BIT];
        scroll_r <= wb_dat_i[aic_pkg::CTRL_SCROLL_BIT];
        auto_r <= wb_dat_i[aic_pkg::CTRL_AUTO_BIT];
      end
    end
  end

  // Analog menu keys behave as rotary selectors.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sens_r <= aic_pkg::SENS_RESET;
      ofs_r <= aic_pkg::OFS_RESET;
    end else if (wr & wb_sel_i[0] & (wb_adr_i == aic_pkg::ADR_CMD)) begin
      if (wb_dat_i[aic_pkg::CMD_SENS_BIT]) begin
        sens_r <= sens_step(sens_r); // see R11
      end
      if (wb_dat_i[aic_pkg::CMD_OFS_BIT]) begin
        ofs_r <= ofs_step(ofs_r); // see R12
      end
    end
  end

  // Arm snapshots the setup so it stays still while the capture side reads it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
      arm_tgl_r <= 1'b0;
      snap_r <= '0;
    end else if (arm_cmd & ~busy_r) begin
      busy_r <= 1'b1;
      arm_tgl_r <= ~arm_tgl_r;
      snap_r <= '{latch: mode_r, period: period_r, analog: analog_r & ~scroll_r,
                  scroll: scroll_r, line: sel_r};
    end else if (done_ev) begin
      busy_r <= 1'b0;
    end
  end

  // Scroll line selection and numbering; an advance outranks a number entry.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_r <= 3'h0;
      for (int i = 0; i < aic_pkg::SCROLL_LINES; i++) begin
        lnum_r[i] <= 7'h00; // see R14
      end
    end else if (adv) begin
      sel_r <= 3'(sel_r + 3'h1); // see R16
      lnum_r[3'(sel_r + 3'h1)] <= lnum_step(lnum_r[sel_r]); // see R14
    end else if (wr & wb_sel_i[0] & (wb_adr_i == aic_pkg::ADR_LINENUM)
                 & (wb_dat_i[6:0] <= aic_pkg::LNUM_MAX) & (wb_dat_i[7] == 1'b0)) begin
      lnum_r[sel_r] <= wb_dat_i[6:0]; // see R14
    end
  end

  // Memory read handshake toward the capture domain.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_st_r <= aic_pkg::RD_IDLE;
      rd_idx_r <= '0;
      rq_tgl_r <= 1'b0;
    end else begin
      case (rd_st_r)
        aic_pkg::RD_IDLE: begin
          if (rd & is_mem) begin
            rd_idx_r <= wb_adr_i[2 +: AW];
            rq_tgl_r <= ~rq_tgl_r;
            rd_st_r <= aic_pkg::RD_WAIT;
          end
        end
        aic_pkg::RD_WAIT: begin
          if (rak_ev) begin
            rd_st_r <= aic_pkg::RD_IDLE;
          end
        end
        default: rd_st_r <= aic_pkg::RD_IDLE;
      endcase
    end
  end

  // Toggle synchronisers from the capture domain.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {rak_s1_r, rak_s2_r, rak_s3_r} <= 3'h0;
      {dn_s1_r, dn_s2_r, dn_s3_r} <= 3'h0;
    end else begin
      {rak_s3_r, rak_s2_r, rak_s1_r} <= {rak_s2_r, rak_s1_r, rak_tgl_r};
      {dn_s3_r, dn_s2_r, dn_s1_r} <= {dn_s2_r, dn_s1_r, done_tgl_r};
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign sens_o = sens_r;
  assign offset_o = ofs_r;
  assign auto_scroll_indicator_o = scroll_r & auto_r;
  assign busy_o = busy_r;

  // ---------------- Capture clock domain ----------------

  logic lr_s1_r, lrst_r;
  logic [7:0] pr_s1_r, pr_s2_r;
  logic [3:0] ad_s1_r, ad_s2_r;
  logic am_s1_r, am_s2_r, am_s3_r;
  logic rq_s1_r, rq_s2_r, rq_s3_r;
  aic_pkg::aic_cfg_t cfg_r;
  logic [7:0] cnt_r;
  logic [7:0] last_r;
  logic [7:0] det_r;
  logic [7:0] hold_r;
  logic [7:0] hval_r;
  logic rec_act_r;
  logic [AW-1:0] waddr_r;
  logic [7:0] mem_r [DEPTH];

  logic tick, arm_ev, rq_ev;
  logic [7:0] lat_en, glit, rec;

  assign tick = (cnt_r == 8'h00);
  assign arm_ev = am_s2_r ^ am_s3_r;
  assign rq_ev = rq_s2_r ^ rq_s3_r;
  // The fastest period leaves no room between edges, so latching is switched off.
  assign lat_en = cfg_r.latch & {8{cfg_r.period != aic_pkg::PERIOD_FASTEST}}; // see R7
  // A glitch is a transition seen in the interval whose level has come back by the edge.
  assign glit = {8{tick}} & lat_en & det_r & ~(pr_s2_r ^ last_r); // see R4

  // Recorded word: glitch flag, then its second interval, else the sampled level.
  always_comb begin
    rec = pr_s2_r; // see R3
    for (int i = 0; i < 8; i++) begin
      if (glit[i]) begin
        rec[i] = ~last_r[i]; // see R5 see R8
      end else if (hold_r[i]) begin
        rec[i] = hval_r[i]; // see R5
      end
    end
    if (cfg_r.analog) begin
      rec[3:0] = ad_s2_r; // see R10
    end
  end

  // Reset and probe synchronisers on the capture clock.
  always_ff @(posedge cap_clk_i) begin
    lr_s1_r <= rst_i;
    lrst_r <= lr_s1_r;
    pr_s1_r <= probe_i;
    pr_s2_r <= pr_s1_r;
    ad_s1_r <= adc_i;
    ad_s2_r <= ad_s1_r;
  end

  // Toggle synchronisers from the system domain; setup is latched at the arm event.
  always_ff @(posedge cap_clk_i) begin
    if (lrst_r) begin
      {am_s1_r, am_s2_r, am_s3_r} <= 3'h0;
      {rq_s1_r, rq_s2_r, rq_s3_r} <= 3'h0;
      cfg_r <= '{latch: 8'h00, period: aic_pkg::PERIOD_RESET, analog: 1'b0,
                 scroll: 1'b0, line: 3'h0};
    end else begin
      {am_s3_r, am_s2_r, am_s1_r} <= {am_s2_r, am_s1_r, arm_tgl_r};
      {rq_s3_r, rq_s2_r, rq_s1_r} <= {rq_s2_r, rq_s1_r, rq_tgl_r};
      if (arm_ev) begin
        cfg_r <= snap_r;
      end
    end
  end

  // Active capture edges every period cycles of the capture clock.
  always_ff @(posedge cap_clk_i) begin
    if (lrst_r) begin
      cnt_r <= 8'h00;
    end else if (tick | arm_ev) begin
      cnt_r <= 8'(cfg_r.period - 8'h01);
    end else begin
      cnt_r <= 8'(cnt_r - 8'h01);
    end
  end

  // Between-edge detectors watch every capture clock cycle, not only edges.
  always_ff @(posedge cap_clk_i) begin
    if (lrst_r) begin
      det_r <= 8'h00;
      last_r <= 8'h00;
      hold_r <= 8'h00;
      hval_r <= 8'h00;
    end else if (tick) begin
      det_r <= 8'h00; // see R18
      last_r <= pr_s2_r;
      hold_r <= glit;
      hval_r <= ~last_r;
    end else begin
      det_r <= det_r | (pr_s2_r ^ last_r); // see R6
    end
  end

  // Recording fills the memory once per arm; scroll writes only the selected line.
  always_ff @(posedge cap_clk_i) begin
    if (lrst_r) begin
      rec_act_r <= 1'b0;
      waddr_r <= '0;
      done_tgl_r <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= 8'h00;
      end
    end else if (arm_ev) begin
      rec_act_r <= 1'b1;
      waddr_r <= '0;
    end else if (tick & rec_act_r) begin
      if (cfg_r.scroll) begin
        mem_r[waddr_r][cfg_r.line] <= pr_s2_r[7]; // see R13 see R17
      end else begin
        mem_r[waddr_r] <= rec;
      end
      waddr_r <= AW'(waddr_r + 1'b1);
      if (waddr_r == AW'(DEPTH - 1)) begin
        rec_act_r <= 1'b0;
        done_tgl_r <= ~done_tgl_r;
      end
    end
  end

  // Memory read service; the index is held still by the requester meanwhile.
  always_ff @(posedge cap_clk_i) begin
    if (lrst_r) begin
      rd_data_r <= 8'h00;
      rak_tgl_r <= 1'b0;
    end else if (rq_ev) begin
      rd_data_r <= mem_r[rd_idx_r];
      rak_tgl_r <= ~rak_tgl_r;
    end
  end

  // ---------------- Assertions ----------------

  a_reset_sample_mode: assert property (@(posedge clk_i) rst_i |=> mode_r == 8'h00) // see R9
    else $error("modes not sample after reset");

  a_mode_write_exact: assert property (@(posedge clk_i) disable iff (rst_i) // see R1
    (wr & wb_sel_i[0] & (wb_adr_i == aic_pkg::ADR_MODE)) |=> mode_r == $past(wb_dat_i[7:0]))
    else $error("per channel mode write lost");

  a_group_lower_only: assert property (@(posedge clk_i) disable iff (rst_i) // see R2
    (wr & wb_sel_i[0] & (wb_adr_i == aic_pkg::ADR_GROUP) & ~wb_dat_i[0] & wb_dat_i[1])
    |=> (mode_r[4:0] == 5'h1F) && (mode_r[7:5] == $past(mode_r[7:5])))
    else $error("lower group command wrong");

  a_sens_cycles: assert property (@(posedge clk_i) disable iff (rst_i) // see R11
    (wr & wb_sel_i[0] & (wb_adr_i == aic_pkg::ADR_CMD) & wb_dat_i[2] & (sens_r == 2'h2))
    |=> sens_r == 2'h0)
    else $error("sensitivity did not wrap");

  a_offset_range: assert property (@(posedge clk_i) disable iff (rst_i) // see R12
    (ofs_r <= 4'h5) || (ofs_r >= 4'hB))
    else $error("offset out of range");

  a_line_num_range: assert property (@(posedge clk_i) disable iff (rst_i) // see R14
    lnum_r[sel_r] <= 7'h63)
    else $error("line number above 99");

  a_step_advance: assert property (@(posedge clk_i) disable iff (rst_i) // see R16
    step_cmd |=> sel_r == 3'($past(sel_r) + 3'h1))
    else $error("step did not advance line");

  a_fast_no_glitch: assert property (@(posedge cap_clk_i) disable iff (lrst_r) // see R7
    (cfg_r.period == 8'h01) |-> glit == 8'h00)
    else $error("glitch flagged at fastest period");

  a_glitch_two_cells: assert property (@(posedge cap_clk_i) disable iff (lrst_r) // see R5
    (glit != 8'h00) |=> ((hold_r & $past(glit)) == $past(glit))
                        && ((hval_r & $past(glit)) == (~$past(last_r) & $past(glit))))
    else $error("glitch not held a second cell");

  a_detector_cleared: assert property (@(posedge cap_clk_i) disable iff (lrst_r) // see R18
    tick |=> det_r == 8'h00)
    else $error("detector not cleared at edge");

  a_analog_routed: assert property (@(posedge cap_clk_i) disable iff (lrst_r) // see R10
    cfg_r.analog |-> rec[3:0] == ad_s2_r)
    else $error("analog data not on channels 0 to 3");

endmodule

// ### dv/aic_sut_model.sv
`timescale 1ns/100ps

// Stand-in for the system under test: it makes the capture clock and drives the probes.
module aic_sut_model (
  input wire logic [7:0] level_i,
  input wire logic [3:0] adc_lvl_i,
  output logic cap_clk_o,
  output logic [7:0] probe_o,
  output logic [3:0] adc_o
);
  logic [7:0] pulse_r;

  // The clock runs free, offset so that it keeps no phase relation to the bus clock.
  initial begin
    cap_clk_o = 1'b0;
    pulse_r = 8'h00;
    probe_o = 8'h00;
    adc_o = 4'h0;
    #7;
    forever #16 cap_clk_o = ~cap_clk_o;
  end

  // Levels move just after our own edge, as a clocked source would drive them.
  always @(posedge cap_clk_o) begin
    probe_o <= level_i ^ pulse_r;
    adc_o <= adc_lvl_i;
  end

  // One capture cycle wide pulse on the masked probes, after a delay in capture cycles.
  task automatic glitch(input logic [7:0] mask, input int dly);
    repeat (dly) @(posedge cap_clk_o);
    pulse_r <= mask;
    @(posedge cap_clk_o);
    pulse_r <= 8'h00;
  endtask
endmodule

// ### dv/test_aic_capture.sv
`timescale 1ns/100ps

module test_aic_capture;
  localparam int DEPTH = 8;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [3:0] sel_val = 4'hF;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0] level = 8'h00;
  logic [3:0] adc_lvl = 4'h0;
  logic cap_clk;
  logic [7:0] probe;
  logic [3:0] adc;
  logic [1:0] sens_o;
  logic [3:0] offset_o;
  logic auto_scroll_indicator_o;
  logic busy_o;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc_cnt = 0;
  logic [15:0] lfsr = 16'h0010;
  logic [7:0] mem [DEPTH];
  logic [31:0] rd;
  logic [7:0] lv;
  logic [7:0] m;
  logic [3:0] ofs_exp;
  int n1;

  // The bus clock; the capture clock comes from the partner model.
  always #10 clk_i = ~clk_i;

  aic_capture #(.DEPTH(DEPTH)) aic_capture_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cap_clk_i(cap_clk), .probe_i(probe),
    .adc_i(adc), .sens_o(sens_o), .offset_o(offset_o),
    .auto_scroll_indicator_o(auto_scroll_indicator_o), .busy_o(busy_o));

  aic_sut_model aic_sut_model_inst (
    .level_i(level), .adc_lvl_i(adc_lvl), .cap_clk_o(cap_clk), .probe_o(probe),
    .adc_o(adc));

  // Repeatable pseudo-random bytes from a fixed starting state.
  function automatic logic [7:0] rand8();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction

  // The offset key walks down one volt at a time and wraps from the bottom to the top.
  function automatic logic [3:0] ofs_step(input logic [3:0] v);
    return (v == aic_pkg::OFS_MIN) ? aic_pkg::OFS_MAX : v - 4'h1;
  endfunction

  // Number of recorded cells on one channel that differ from the steady level.
  function automatic int cnt(input int ch, input logic lvl);
    int c;
    c = 0;
    for (int i = 0; i < DEPTH; i++) c += (mem[i][ch] !== lvl) ? 1 : 0;
    return c;
  endfunction

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One classic cycle: request held until ack is sampled high, then released.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= sel_val;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 200);
    if (n >= 200) chk("ack", 32'h1, 32'h0);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    wb_sel_i <= 4'h0;
  endtask

  // Arm, optionally glitch the probes mid-run, wait for the end and fetch all cells.
  task automatic record(input logic [7:0] mask, input int dly);
    int n;
    wb(1'b1, aic_pkg::ADR_CMD, 32'h1);
    @(posedge clk_i);
    chk("busy", 32'h1, 32'(busy_o));
    if (mask != 8'h00) aic_sut_model_inst.glitch(mask, dly);
    n = 0;
    while (busy_o === 1'b1 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    chk("done", 32'h0, 32'(busy_o));
    for (int i = 0; i < DEPTH; i++) begin
      wb(1'b0, 8'h40 + 8'(4 * i), 32'h0);
      mem[i] = rd[7:0];
    end
  endtask

  // A hang is cut short well beyond the thousand-odd cycles the sequence needs.
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      error_cnt++;
      end_sim();
    end
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    wb(1'b0, aic_pkg::ADR_MODE, 32'h0);
    chk("mode_rst", 32'h0, rd);
    wb(1'b0, aic_pkg::ADR_STATUS, 32'h0);
    chk("status_rst", 32'h0, rd);
    wb(1'b0, 8'h3C, 32'h0);
    chk("unmapped", 32'h0, rd);
    repeat (4) begin
      lv = rand8();
      wb(1'b1, aic_pkg::ADR_MODE, 32'(lv));
      wb(1'b0, aic_pkg::ADR_MODE, 32'h0);
      chk("mode", 32'(lv), rd);
    end
    // Group commands in the order latch-high, latch-low, sample-low, sample-high.
    m = lv;
    for (int k = 0; k < 4; k++) begin
      logic [1:0] g;
      logic [7:0] sel;
      g = 2'(8'h4B >> (2 * k));
      sel = g[0] ? aic_pkg::GRP_HIGH_MASK : aic_pkg::GRP_LOW_MASK;
      m = g[1] ? (m | sel) : (m & ~sel);
      wb(1'b1, aic_pkg::ADR_GROUP, 32'(g));
      wb(1'b0, aic_pkg::ADR_MODE, 32'h0);
      chk("group", 32'(m), rd);
    end
    // A mode write without its low byte lane must leave every channel alone.
    sel_val = 4'hE;
    wb(1'b1, aic_pkg::ADR_MODE, 32'(~m));
    sel_val = 4'hF;
    wb(1'b0, aic_pkg::ADR_MODE, 32'h0);
    chk("mode_sel", 32'(m), rd);
    for (int k = 1; k <= 4; k++) begin
      wb(1'b1, aic_pkg::ADR_CMD, 32'h4);
      @(posedge clk_i);
      chk("sens", 32'(k % 3), 32'(sens_o));
    end
    ofs_exp = aic_pkg::OFS_RESET;
    repeat (12) begin
      wb(1'b1, aic_pkg::ADR_CMD, 32'h8);
      @(posedge clk_i);
      ofs_exp = ofs_step(ofs_exp);
      chk("offset", 32'(ofs_exp), 32'(offset_o));
    end
    // Channels 0 and 2 latch, 1 samples; 0 and 1 get the same narrow pulse twice.
    lv = rand8();
    level <= lv;
    wb(1'b1, aic_pkg::ADR_MODE, 32'h05);
    wb(1'b1, aic_pkg::ADR_CTRL, 32'h04);
    for (int r = 0; r < 2; r++) begin
      record(8'h03, 14 + 3 * r);
      n1 = cnt(1, lv[1]);
      chk("sample_cells", 32'h1, 32'(n1 <= 1));
      if (n1 == 0) chk("glitch_cells", 32'h2, 32'(cnt(0, lv[0])));
      chk("quiet_latch", 32'h0, 32'(cnt(2, lv[2])));
      for (int i = 0; i < DEPTH; i++) chk("other", 32'(lv[7:3]), 32'(mem[i][7:3]));
    end
    wb(1'b1, aic_pkg::ADR_CTRL, 32'(aic_pkg::PERIOD_FASTEST));
    record(8'h03, 2);
    chk("fastest_hit", 32'h1, 32'(cnt(1, lv[1])));
    chk("fastest", 32'(cnt(1, lv[1])), 32'(cnt(0, lv[0])));
    // Analog run: converter on the low four channels, probes on the high four.
    lv = rand8();
    level <= lv;
    adc_lvl <= lv[3:0] ^ 4'hA;
    wb(1'b1, aic_pkg::ADR_CTRL, 32'h104);
    record(8'h00, 0);
    for (int i = 0; i < DEPTH; i++) chk("analog", 32'({lv[7:4], lv[3:0] ^ 4'hA}), 32'(mem[i]));
    wb(1'b1, aic_pkg::ADR_CMD, 32'h2);
    wb(1'b0, aic_pkg::ADR_STATUS, 32'h0);
    chk("no_scroll_step", 32'h0, 32'(rd[3:1]));
    wb(1'b1, aic_pkg::ADR_CTRL, 32'h204);
    for (int k = 0; k < 8; k++) begin
      wb(1'b1, aic_pkg::ADR_CMD, 32'h2);
      wb(1'b0, aic_pkg::ADR_STATUS, 32'h0);
      chk("line", 32'((k + 1) % 8), 32'(rd[3:1]));
      chk("line_num", 32'(k + 1), 32'(rd[10:4]));
    end
    level <= 8'h80;
    record(8'h00, 0);
    for (int i = 0; i < DEPTH; i++) chk("scroll_hi", 32'h1, 32'(mem[i][0]));
    level <= 8'h7F;
    record(8'h00, 0);
    for (int i = 0; i < DEPTH; i++) chk("scroll_redo", 32'h0, 32'(mem[i][0]));
    wb(1'b1, aic_pkg::ADR_LINENUM, 32'd99);
    wb(1'b1, aic_pkg::ADR_LINENUM, 32'd100);
    wb(1'b0, aic_pkg::ADR_STATUS, 32'h0);
    chk("num_refused", 32'd99, 32'(rd[10:4]));
    wb(1'b1, aic_pkg::ADR_CMD, 32'h2);
    wb(1'b0, aic_pkg::ADR_STATUS, 32'h0);
    chk("wrap_num", 32'h0, 32'(rd[10:4]));
    wb(1'b1, aic_pkg::ADR_CTRL, 32'h604);
    @(posedge clk_i);
    chk("auto_ind", 32'h1, 32'(auto_scroll_indicator_o));
    record(8'h00, 0);
    wb(1'b0, aic_pkg::ADR_STATUS, 32'h0);
    chk("auto_line", 32'h2, 32'(rd[3:1]));
    chk("auto_num", 32'h1, 32'(rd[10:4]));
    end_sim();
  end
endmodule
